//--- src/eth_rx_pkg.sv
package eth_rx_pkg;
  localparam int CLK_NS = 50;
  localparam int IDLE_WIN_NS = 40000;
  localparam int IDLE_WIN_CYC = IDLE_WIN_NS / CLK_NS;
  localparam int NLP_PERIOD_NS = 16000000;
  localparam int NLP_PERIOD_CYC = NLP_PERIOD_NS / CLK_NS;
  localparam int NLP_WIDTH_NS = 100;
  localparam int NLP_WIDTH_CYC = (NLP_WIDTH_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_BITS = 60;
  localparam int IDLE_RUN_BITS = 10;
  localparam logic [7:0] CTRL_ADDR = 8'h7C;
  localparam logic [7:0] STAT_ADDR = 8'h80;
  localparam int CTRL_BYPASS_BIT = 0;
  localparam int CTRL_DECODE_BIT = 6;
  localparam logic [7:0] CTRL_RESET = 8'h40;
  localparam logic [4:0] CG_J = 5'h18;
  localparam logic [4:0] CG_K = 5'h11;
  localparam logic [4:0] CG_T = 5'h0D;
  localparam logic [4:0] CG_R = 5'h07;
  localparam logic [4:0] CG_IDLE = 5'h1F;
  localparam logic [3:0] NIB_SSD = 4'h5;
  localparam logic [3:0] NIB_BAD_SSD = 4'hE;
  localparam int PIN_SIG = 0;
  localparam int PIN_RMII = 1;
  localparam int PIN_HDX = 2;
  localparam int PIN_10M = 3;
  localparam int PIN_LFAIL = 4;
  localparam int NPIN = 5;
  typedef enum logic [2:0] {
    ST_HUNT = 3'b001,
    ST_SSD = 3'b010,
    ST_FRAME = 3'b100
  } rx_state_t;
endpackage

//--- src/eth_phy_pcs.sv
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/10ps
module eth_phy_pcs
  import eth_rx_pkg::*;
#(
  parameter int NLP_PERIOD = NLP_PERIOD_CYC
)
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Register bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Recovered receive bits and status pins
  input wire logic rx_bit_i,
  input wire logic rx_bit_valid_i,
  input wire logic signal_present_flag_i,
  input wire logic link_fail_i,
  input wire logic rmii_mode_i,
  input wire logic ten_meg_i,
  input wire logic half_duplex_i,
  // MAC receive side
  output logic [3:0] rxd_o,
  output logic rx_dv_o,
  output logic rx_error_or_fifth_bit_pin_o,
  output logic crs_o,
  output logic col_o,
  output logic rx_stb_o,
  output logic [1:0] rmii_rxd_o,
  output logic crs_dv_o,
  // MAC transmit side and line
  input wire logic tx_en_i,
  input wire logic [3:0] txd_i,
  output logic tx_clk_o,
  output logic tx_line_o,
  output logic tx_active_o
);

  function automatic logic [4:0] dec5b(input logic [4:0] g);
    logic [4:0] r;
    r = 5'h00;
    unique case (g)
      5'h1E: r = 5'h10;
      5'h09: r = 5'h11;
      5'h14: r = 5'h12;
      5'h15: r = 5'h13;
      5'h0A: r = 5'h14;
      5'h0B: r = 5'h15;
      5'h0E: r = 5'h16;
      5'h0F: r = 5'h17;
      5'h12: r = 5'h18;
      5'h13: r = 5'h19;
      5'h16: r = 5'h1A;
      5'h17: r = 5'h1B;
      5'h1A: r = 5'h1C;
      5'h1B: r = 5'h1D;
      5'h1C: r = 5'h1E;
      5'h1D: r = 5'h1F;
      default: r = 5'h00;
    endcase
    return r;
  endfunction

  // Pin synchronisers
  logic [NPIN-1:0] pin_s1_r, pin_s2_r, pin_s3_r, pin_r;
  wire [NPIN-1:0] pin_raw = {link_fail_i, ten_meg_i, half_duplex_i, rmii_mode_i,
    signal_present_flag_i};
  wire [NPIN-1:0] pin_nxt = (pin_s2_r & pin_s3_r) | (pin_r & (pin_s2_r | pin_s3_r));
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
      pin_s3_r <= '0;
      pin_r <= '0;
    end
    else
    begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      pin_r <= pin_nxt;
    end
  end
  wire sig_ok = pin_r[PIN_SIG];
  wire rmii = pin_r[PIN_RMII];
  wire loop_mode = pin_r[PIN_10M] & pin_r[PIN_HDX];
  wire ten_meg = pin_r[PIN_10M];

  // Registers
  logic [7:0] ctrl_r;
  logic wait_r;
  logic [31:0] rdata_r;
  logic locked_r;
  rx_state_t st_r;
  wire bypass = ctrl_r[CTRL_BYPASS_BIT];
  wire raw_mode = !ctrl_r[CTRL_DECODE_BIT] & !rmii;
  wire acc = avs_read_i | avs_write_i;
  wire hit_ctrl = avs_address_i == CTRL_ADDR;
  wire hit_stat = avs_address_i == STAT_ADDR;
  wire [31:0] rd_val = hit_ctrl ? {24'h000000, ctrl_r} :
    hit_stat ? {27'h0000000, st_r == ST_FRAME, sig_ok, rmii, ten_meg, locked_r} : 32'h00000000;
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_r <= CTRL_RESET;
      wait_r <= 1'b1;
      rdata_r <= '0;
    end
    else
    begin
      wait_r <= !(acc & wait_r);
      rdata_r <= rd_val;
      if (avs_write_i & !wait_r & hit_ctrl & avs_byteenable_i[0])
        ctrl_r <= avs_writedata_i[7:0];
    end
  end
  assign avs_waitrequest_o = wait_r;
  assign avs_readdata_o = rdata_r;

  // Descrambler
  logic [10:0] key_r;
  logic [6:0] match_r;
  logic [3:0] ones_r;
  logic [9:0] wd_r;
  wire key_bit = key_r[10] ^ key_r[8];
  wire plain = bypass ? rx_bit_i : rx_bit_i ^ key_bit;
  wire desc_ok = locked_r | bypass;
  wire idle_run = rx_bit_valid_i & plain & (ones_r == 4'(IDLE_RUN_BITS - 1));
  wire timeout = locked_r & !bypass & (wd_r == 10'(IDLE_WIN_CYC - 1));
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      key_r <= '0;
      match_r <= '0;
      locked_r <= 1'b0;
      ones_r <= '0;
      wd_r <= '0;
    end
    else
    begin
      wd_r <= (idle_run | timeout | !locked_r) ? 10'h000 : wd_r + 10'h001;
      if (timeout)
      begin
        locked_r <= 1'b0;
        match_r <= '0;
      end
      else if (rx_bit_valid_i)
      begin
        ones_r <= !plain ? 4'h0 : idle_run ? ones_r : ones_r + 4'h1;
        key_r <= {key_r[9:0], locked_r ? key_bit : ~rx_bit_i};
        if (!locked_r)
        begin
          match_r <= (~rx_bit_i == key_bit) ? match_r + 7'h01 : 7'h00;
          if (match_r == 7'(SYNC_BITS - 1))
            locked_r <= 1'b1;
        end
      end
    end
  end

  // Alignment and decoding
  logic [9:0] sr_r;
  logic [2:0] bcnt_r;
  logic t_seen_r, i_seen_r, pend_r;
  logic [3:0] p_rxd_r;
  logic p_dv_r, p_er_r, p_crs_r, p_stb_r, p_fifth_r;
  wire [4:0] grp = {sr_r[3:0], plain};
  wire [9:0] win = {sr_r[8:0], plain};
  wire [4:0] dec = dec5b(grp);
  wire grp_done = rx_bit_valid_i & (bcnt_r == 3'd4);
  wire stop = timeout | !sig_ok | pin_r[PIN_LFAIL];
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      st_r <= ST_HUNT;
      sr_r <= '1;
      bcnt_r <= '0;
      t_seen_r <= 1'b0;
      i_seen_r <= 1'b0;
      pend_r <= 1'b0;
      p_rxd_r <= '0;
      p_dv_r <= 1'b0;
      p_er_r <= 1'b0;
      p_crs_r <= 1'b0;
      p_stb_r <= 1'b0;
      p_fifth_r <= 1'b0;
    end
    else
    begin
      p_stb_r <= 1'b0;
      if (rx_bit_valid_i)
        sr_r <= win;
      if (stop)
      begin
        st_r <= ST_HUNT;
        p_dv_r <= 1'b0;
        p_crs_r <= 1'b0;
        p_er_r <= 1'b0;
        pend_r <= 1'b0;
      end
      else
      begin
        unique case (st_r)
          ST_HUNT:
          begin
            if (rx_bit_valid_i & desc_ok & !plain)
            begin
              st_r <= ST_SSD;
              bcnt_r <= '0;
              p_crs_r <= 1'b1;
              p_er_r <= 1'b0;
            end
          end
          ST_SSD:
          begin
            if (rx_bit_valid_i)
            begin
              bcnt_r <= bcnt_r + 3'd1;
              if (bcnt_r == 3'd6)
              begin
                bcnt_r <= '0;
                p_stb_r <= 1'b1;
                if (win == {CG_J, CG_K})
                begin
                  st_r <= ST_FRAME;
                  p_rxd_r <= NIB_SSD;
                  p_dv_r <= 1'b1;
                  p_er_r <= 1'b0;
                  pend_r <= 1'b1;
                  t_seen_r <= 1'b0;
                  i_seen_r <= 1'b0;
                end
                else
                begin
                  st_r <= ST_HUNT;
                  p_rxd_r <= NIB_BAD_SSD;
                  p_er_r <= 1'b1;
                  p_crs_r <= 1'b0;
                end
              end
            end
          end
          ST_FRAME:
          begin
            if (rx_bit_valid_i)
              bcnt_r <= (bcnt_r == 3'd4) ? 3'd0 : bcnt_r + 3'd1;
            if (pend_r & rx_bit_valid_i & bcnt_r == 3'd1)
            begin
              pend_r <= 1'b0;
              p_stb_r <= 1'b1;
            end
            if (grp_done)
            begin
              p_er_r <= 1'b0;
              if (raw_mode & grp != CG_T & grp != CG_IDLE)
              begin
                p_stb_r <= 1'b1;
                p_rxd_r <= grp[3:0];
                p_fifth_r <= grp[4];
              end
              if (t_seen_r)
              begin
                t_seen_r <= 1'b0;
                if (grp == CG_R)
                begin
                  st_r <= ST_HUNT;
                  p_dv_r <= 1'b0;
                  p_crs_r <= 1'b0;
                end
                else
                begin
                  p_er_r <= 1'b1;
                  p_stb_r <= 1'b1;
                end
              end
              else if (grp == CG_T)
                t_seen_r <= 1'b1;
              else if (grp == CG_IDLE)
              begin
                i_seen_r <= 1'b1;
                if (i_seen_r)
                begin
                  st_r <= ST_HUNT;
                  p_dv_r <= 1'b0;
                  p_crs_r <= 1'b0;
                end
              end
              else
              begin
                i_seen_r <= 1'b0;
                p_stb_r <= 1'b1;
                if (!raw_mode)
                begin
                  p_rxd_r <= dec[3:0];
                  p_er_r <= !dec[4];
                end
              end
            end
          end
          default: st_r <= ST_HUNT;
        endcase
      end
    end
  end

  // 10M transmit: nibble latch, Manchester, link pulses
  logic [2:0] ph_r;
  logic [1:0] lo_r;
  logic [3:0] sh_r;
  logic act_r;
  logic [18:0] nlp_r;
  wire [1:0] dib = tx_en_i ? txd_i[1:0] : 2'b00;
  wire [3:0] nib = rmii ? {dib, lo_r} : txd_i;
  wire tbit = sh_r[ph_r[2:1]];
  wire manch = ph_r[0] ? tbit : ~tbit;
  wire nlp_on = nlp_r < 19'(NLP_WIDTH_CYC);
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ph_r <= '0;
      lo_r <= '0;
      sh_r <= '0;
      act_r <= 1'b0;
      nlp_r <= '0;
      tx_clk_o <= 1'b0;
      tx_line_o <= 1'b0;
    end
    else
    begin
      ph_r <= ph_r + 3'd1;
      tx_clk_o <= ph_r[2];
      if (ph_r == 3'd3)
        lo_r <= dib;
      if (ph_r == 3'd7)
      begin
        sh_r <= nib;
        act_r <= tx_en_i;
      end
      nlp_r <= (act_r | nlp_r == 19'(NLP_PERIOD - 1)) ? 19'h00000 : nlp_r + 19'h00001;
      tx_line_o <= ten_meg & (act_r ? manch : nlp_on);
    end
  end
  assign tx_active_o = act_r;

  // Output stage
  logic hi_r;
  logic [3:0] rmii_nib_r;
  wire lb_stb = ph_r == 3'd0;
  always_ff @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rxd_o <= '0;
      rx_dv_o <= 1'b0;
      rx_error_or_fifth_bit_pin_o <= 1'b0;
      crs_o <= 1'b0;
      col_o <= 1'b0;
      rx_stb_o <= 1'b0;
      rmii_rxd_o <= '0;
      crs_dv_o <= 1'b0;
      hi_r <= 1'b0;
      rmii_nib_r <= '0;
    end
    else
    begin
      col_o <= 1'b0;
      if (loop_mode)
      begin
        rxd_o <= sh_r;
        rx_dv_o <= act_r;
        crs_o <= act_r;
        rx_stb_o <= act_r & lb_stb;
        rx_error_or_fifth_bit_pin_o <= 1'b0;
      end
      else
      begin
        rxd_o <= p_rxd_r;
        rx_dv_o <= p_dv_r;
        crs_o <= p_crs_r;
        rx_stb_o <= p_stb_r;
        rx_error_or_fifth_bit_pin_o <= raw_mode ? p_fifth_r : p_er_r;
      end
      crs_dv_o <= rmii & (p_crs_r | p_dv_r);
      hi_r <= rmii & p_stb_r;
      if (rmii & p_stb_r)
      begin
        rmii_rxd_o <= p_rxd_r[1:0];
        rmii_nib_r <= p_rxd_r;
      end
      else if (hi_r)
        rmii_rxd_o <= rmii_nib_r[3:2];
      else if (!p_dv_r)
        rmii_rxd_o <= 2'b00;
    end
  end

endmodule

//--- testbench/eth_phy_pcs_sva.sv
`timescale 1ns/10ps
module eth_phy_pcs_sva
  import eth_rx_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // Register bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // Port pins
  input wire logic ten_meg_i,
  input wire logic tx_en_i,
  input wire logic [3:0] rxd_o,
  input wire logic rx_dv_o,
  input wire logic crs_o,
  input wire logic rx_stb_o,
  input wire logic tx_clk_o,
  input wire logic tx_line_o,
  input wire logic tx_active_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!resetn_i);
  a_dv_with_crs: assert property (rx_dv_o |-> crs_o)
    else $error("valid without carrier");
  a_dv_rise_ssd: assert property ($rose(rx_dv_o) && !ten_meg_i |-> rx_stb_o && rxd_o == NIB_SSD)
    else $error("valid rose without first start nibble");
  a_ack_follows_req: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("bus answer late");
  a_ack_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("bus answer longer than one cycle");
  a_unmapped_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i != CTRL_ADDR
    && avs_address_i != STAT_ADDR |-> avs_readdata_o == 32'h0)
    else $error("unmapped read not zero");
  a_tx_clk_period: assert property ($rose(tx_clk_o) |=> (!$rose(tx_clk_o)) [*7] ##1 $rose(tx_clk_o))
    else $error("transmit clock period not 8");
  a_tx_latch_en: assert property ($rose(tx_active_o) |-> $past(tx_en_i) ##0 tx_active_o [*8])
    else $error("transmit nibble latched badly");
  a_manchester_mix: assert property (ten_meg_i && tx_active_o && $past(tx_active_o, 3)
    |-> !(tx_line_o == $past(tx_line_o) && tx_line_o == $past(tx_line_o, 2)))
    else $error("line run too long for Manchester");
  a_strobe_pulse: assert property (rx_stb_o |=> !rx_stb_o)
    else $error("receive strobe longer than one cycle");
endmodule

//--- testbench/mac_partner.sv
`timescale 1ns/10ps
module mac_partner
(
  // Clock, reset and transmit clock
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic tx_clk_i,
  // Transmit nibbles toward the port
  output logic tx_en_o = 1'b0,
  output logic [3:0] txd_o = 4'h0
);
  logic [3:0] txq[$];
  logic clk_d_r = 1'b0;
  // New nibble after the falling transmit clock, settled for the rising one
  always @(posedge clk_sys_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      clk_d_r <= 1'b0;
      tx_en_o <= 1'b0;
      txd_o <= 4'h0;
    end
    else
    begin
      clk_d_r <= tx_clk_i;
      if (clk_d_r && !tx_clk_i)
      begin
        tx_en_o <= txq.size() != 0;
        if (txq.size() != 0)
          txd_o <= txq.pop_front();
        else
          txd_o <= 4'h0;
      end
    end
  end
endmodule

//--- testbench/fast_ethernet_rx_pcs_and_10m_tx_port_test.sv
`timescale 1ns/10ps
module fast_ethernet_rx_pcs_and_10m_tx_port_test;
  import eth_rx_pkg::*;
  localparam int NLP = 64;
  localparam logic [4:0] ENC [16] = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
    5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
  logic clk_sys_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'h1;
  logic rx_bit_i = 1'b1;
  logic rx_bit_valid_i = 1'b0;
  logic signal_present_flag_i = 1'b1;
  logic link_fail_i = 1'b0;
  logic rmii_mode_i = 1'b0;
  logic ten_meg_i = 1'b0;
  logic half_duplex_i = 1'b0;
  logic [31:0] avs_readdata_o;
  logic [3:0] rxd_o, txd_i;
  logic avs_waitrequest_o, rx_dv_o, rx_error_or_fifth_bit_pin_o, crs_o, col_o, rx_stb_o;
  logic tx_en_i, tx_clk_o, tx_line_o, tx_active_o;
  logic [15:0] exq[$];
  logic [10:0] key = 11'h5A3;
  logic scr = 1'b0;
  logic mon_on = 1'b1;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  eth_phy_pcs #(.NLP_PERIOD(NLP)) DUT (.clk_sys_i, .resetn_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o,
    .rx_bit_i, .rx_bit_valid_i, .signal_present_flag_i, .link_fail_i, .rmii_mode_i, .ten_meg_i,
    .half_duplex_i, .rxd_o, .rx_dv_o, .rx_error_or_fifth_bit_pin_o, .crs_o, .col_o, .rx_stb_o,
    .rmii_rxd_o(), .crs_dv_o(), .tx_en_i, .txd_i, .tx_clk_o, .tx_line_o, .tx_active_o);
  mac_partner mac (.clk_sys_i, .resetn_i, .tx_clk_i(tx_clk_o), .tx_en_o(tx_en_i), .txd_o(txd_i));
  always #25 clk_sys_i = ~clk_sys_i;
  task automatic check(input logic [7:0] m, input logic [7:0] v, input logic [7:0] g);
    tests_run++;
    if ((g & m) !== (v & m))
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, g & m, v & m);
    end
  endtask
  task automatic complete_run();
    check(8'hFF, 8'h00, 8'(exq.size()));
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do
      @(negedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0);
    q = avs_readdata_o;
    @(posedge clk_sys_i);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // Sends one code-group MSB first, scrambled on request
  task automatic grp(input logic [4:0] g);
    logic b;
    for (int i = 4; i >= 0; i--)
    begin
      b = g[i];
      if (scr)
      begin
        b = b ^ key[10] ^ key[8];
        key = {key[9:0], key[10] ^ key[8]};
      end
      rx_bit_i <= b;
      rx_bit_valid_i <= 1'b1;
      @(posedge clk_sys_i);
      rx_bit_i <= ~b;
      rx_bit_valid_i <= 1'b0;
      repeat (3) @(posedge clk_sys_i);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) grp(CG_IDLE);
  endtask
  task automatic frame(input logic raw, input logic bad);
    logic [3:0] d;
    idle(3);
    repeat (2) exq.push_back(raw ? 16'h6020 : {8'h7F, 4'b0010, NIB_SSD});
    grp(CG_J);
    grp(CG_K);
    for (int i = 0; i < 6; i++)
    begin
      d = 4'($urandom);
      exq.push_back({8'h7F, raw ? {3'b001, ENC[d]} : {4'b0010, d}});
      grp(ENC[d]);
    end
    if (bad)
      exq.push_back(16'h5010);
    if (bad)
      grp(5'h00);
    grp(CG_T);
    grp(CG_R);
    idle(3);
  endtask
  // Oldest note is compared with each strobed receive nibble while mon_on is set, except a strobe without valid when that note expects valid
  always @(negedge clk_sys_i)
  begin
    logic [7:0] got;
    logic [15:0] e;
    if (rx_stb_o === 1'b1 && mon_on)
    begin
      got = {1'b0, col_o, rx_dv_o, rx_error_or_fifth_bit_pin_o, rxd_o};
      if (exq.size() == 0)
        check(8'h60, 8'h00, got);
      else if (rx_dv_o === 1'b1 || (exq[0][13] & exq[0][5]) !== 1'b1)
      begin
        e = exq.pop_front();
        check(e[15:8], e[7:0], got);
      end
    end
  end
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 30000)
    begin
      check(8'hFF, 8'h00, 8'hFF);
      complete_run();
    end
  end
  initial
  begin
    logic [31:0] q;
    logic [3:0] d;
    logic last;
    int n;
    void'($urandom(32'hD5C8));
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    check(8'h07, 8'h00, {5'h00, rx_dv_o, rx_error_or_fifth_bit_pin_o, crs_o});
    bus(1'b0, CTRL_ADDR, 32'h0, q);
    check(8'hFF, CTRL_RESET, q[7:0]);
    bus(1'b0, 8'h10, 32'h0, q);
    check(8'hFF, 8'h00, q[7:0]);
    bus(1'b0, STAT_ADDR, 32'h0, q);
    check(8'h01, 8'h00, q[7:0]);
    scr = 1'b1;
    idle(20);
    bus(1'b0, STAT_ADDR, 32'h0, q);
    check(8'h01, 8'h01, q[7:0]);
    frame(1'b0, 1'b0);
    mon_on = 1'b0;
    grp(CG_J);
    grp(CG_K);
    repeat (45) grp(ENC[5]);
    check(8'h01, 8'h00, {7'h00, rx_dv_o});
    bus(1'b0, STAT_ADDR, 32'h0, q);
    check(8'h01, 8'h00, q[7:0]);
    mon_on = 1'b1;
    idle(20);
    frame(1'b0, 1'b1);
    bus(1'b1, CTRL_ADDR, 32'h41, q);
    scr = 1'b0;
    frame(1'b0, 1'b0);
    idle(3);
    exq.push_back({8'h7F, 4'b0001, NIB_BAD_SSD});
    grp(CG_J);
    grp(ENC[0]);
    idle(3);
    bus(1'b1, CTRL_ADDR, 32'h01, q);
    frame(1'b1, 1'b0);
    rmii_mode_i <= 1'b1;
    repeat (8) @(posedge clk_sys_i);
    frame(1'b0, 1'b0);
    rmii_mode_i <= 1'b0;
    ten_meg_i <= 1'b1;
    half_duplex_i <= 1'b1;
    repeat (20) @(posedge clk_sys_i);
    n = 0;
    @(negedge clk_sys_i);
    last = tx_line_o === 1'b1;
    repeat (10 * NLP)
    begin
      @(negedge clk_sys_i);
      if (tx_line_o === 1'b1 && !last)
        n++;
      last = tx_line_o === 1'b1;
    end
    check(8'hFF, 8'h0A, 8'(n));
    @(posedge clk_sys_i);
    for (int i = 0; i < 8; i++)
    begin
      d = 4'($urandom);
      exq.push_back({8'h7F, 4'b0010, d});
      mac.txq.push_back(d);
    end
    for (int i = 0; i < 400 && exq.size() != 0; i++)
      @(posedge clk_sys_i);
    repeat (20) @(posedge clk_sys_i);
    complete_run();
  end
endmodule
bind eth_phy_pcs eth_phy_pcs_sva chk (.clk_sys_i, .resetn_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .ten_meg_i, .tx_en_i, .rxd_o, .rx_dv_o,
  .crs_o, .rx_stb_o, .tx_clk_o, .tx_line_o, .tx_active_o);
